// ### rtl/sac_conv.sv
// Contract
// - With select low and busy high, read/convert falling starts a conversion.
// - With read/convert low, select falling starts a conversion.
// - Select and read/convert are ORed; whichever falls last triggers.
// - Busy low from start until result outputs hold the new word.
// - Status high while latchup guard active; data then invalid.
// - A latchup event becomes an internal reset of the converter.
// - Result is 16 bits parallel, MSB on top line, LSB bottom.
// - Acquire plus convert fits a 100 kHz sample rate.
// - Data lines have three-state drivers for a shared bus.
`timescale 1ns/1ps
`default_nettype none
module sac_conv #(
	parameter int unsigned HOLD_CYC = sac_pkg::GUARD_HOLD
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      cs_n,
	input  wire logic                      rc,
	input  wire logic                      latchup_hit,
	input  wire logic                      cmp_hi,
	output logic      [sac_pkg::RES_W-1:0] dac_code,
	output logic                           sample_hold,
	output logic                           busy_n,
	output logic                           latchup_guard,
	output logic      [sac_pkg::RES_W-1:0] result,
	output logic                           result_oe
);
	import sac_pkg::*;

	typedef struct packed {
		logic              cs_s1;
		logic              cs_s2;
		logic              rc_s1;
		logic              rc_s2;
		logic              lu_s1;
		logic              lu_s2;
		logic              trig_prev;
		sac_state_e        st;
		logic [CNT_W-1:0]  cnt;
		logic [BIT_W-1:0]  bitn;
		logic [RES_W-1:0]  trial;
		logic [RES_W-1:0]  res;
		logic              busy_n;
		logic              oe;
		logic              guard;
		logic [CNT_W-1:0]  hold;
	} sac_conv_s;

	sac_conv_s r;
	sac_conv_s next_r;

	logic             f_ready;
	logic             f_valid;
	logic [RES_W-1:0] f_data;
	logic             f_pop;
	logic             trig_low;
	logic             trig_fall;

	////////////////////////////////////////////////////////////////////
	// OR'd trigger
	assign trig_low  = r.cs_s2 | r.rc_s2;
	assign trig_fall = r.trig_prev && !trig_low;
	// Head is held while the host reads, so the bus never changes mid-read
	assign f_pop     = f_valid && !r.oe;

	sac_fifo #(
		.WIDTH (RES_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.clear     (r.lu_s2),
		.in_valid  (r.st == S_DONE),
		.in_ready  (f_ready),
		.in_data   (r.trial),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		next_r.cs_s1 = cs_n;
		next_r.cs_s2 = r.cs_s1;
		next_r.rc_s1 = rc;
		next_r.rc_s2 = r.rc_s1;
		next_r.lu_s1 = latchup_hit;
		next_r.lu_s2 = r.lu_s1;
		next_r.trig_prev = trig_low;

		case (r.st)
			S_IDLE: begin
				if (trig_fall && !r.guard)
					next_r.st = S_CONV;
			end
			S_CONV: begin
				if (r.cnt != '0) begin
					next_r.cnt = r.cnt - 1'b1;
				end else begin
					next_r.trial[r.bitn] = cmp_hi;
					if (r.bitn == BIT_ZERO) begin
						next_r.st = S_DONE;
					end else begin
						next_r.trial[r.bitn - 1'b1] = 1'b1;
						next_r.bitn = r.bitn - 1'b1;
						next_r.cnt = CNT_W'(BIT_CYC - 1);
					end
				end
			end
			S_DONE: begin
				// Full FIFO stalls the converter here
				if (f_ready)
					next_r.st = S_WAIT;
			end
			S_WAIT: begin
				// busy rises with the new word
				if (f_pop) begin
					next_r.busy_n = 1'b1;
					next_r.st = S_ACQ;
					next_r.cnt = CNT_W'(ACQ_CYC - 1);
				end
			end
			S_ACQ: begin
				// busy is high, so a trigger cuts tracking short
				// tracking time closes the sample period
				if (trig_fall && !r.guard)
					next_r.st = S_CONV;
				else if (r.cnt != '0)
					next_r.cnt = r.cnt - 1'b1;
				else
					next_r.st = S_IDLE;
			end
			default: begin
				next_r.st = S_IDLE;
			end
		endcase

		// busy falls as the conversion starts, MSB trial first
		if (next_r.st == S_CONV && r.st != S_CONV) begin
			next_r.busy_n = 1'b0;
			next_r.cnt = CNT_W'(BIT_CYC - 1);
			next_r.bitn = BIT_TOP;
			next_r.trial = TRIAL_MSB;
		end

		if (f_pop)
			next_r.res = f_data;

		// drive only for a read with select low
		next_r.oe = !r.cs_s2 && r.rc_s2 && r.busy_n && !r.guard;

		if (r.hold != '0)
			next_r.hold = r.hold - 1'b1;

		if (r.lu_s2) begin
			next_r.st = S_IDLE;
			next_r.busy_n = 1'b1;
			next_r.cnt = '0;
			next_r.bitn = BIT_ZERO;
			next_r.trial = RES_RESET;
			next_r.res = RES_RESET;
			next_r.oe = 1'b0;
			next_r.hold = CNT_W'(HOLD_CYC);
		end
		next_r.guard = r.lu_s2 || (next_r.hold != '0);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.st <= S_IDLE;
			r.busy_n <= 1'b1;
			r.cs_s1 <= 1'b1;
			r.cs_s2 <= 1'b1;
			r.trig_prev <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign dac_code      = r.trial;
	assign sample_hold   = (r.st == S_CONV);
	assign busy_n        = r.busy_n;
	assign latchup_guard = r.guard;
	assign result        = r.res;
	assign result_oe     = r.oe;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_RC_FALL_START: assert property (
		$fell(r.rc_s2) && !r.cs_s2 && busy_n && !r.guard && !r.lu_s2
		|=> !busy_n && r.st == S_CONV)
		else $error("read/convert fall did not start");

	AST_CS_FALL_START: assert property (
		$fell(r.cs_s2) && !r.rc_s2 && busy_n && !r.guard && !r.lu_s2
		|=> !busy_n)
		else $error("select fall did not start");

	AST_OR_TRIGGER: assert property (
		$fell(busy_n) |-> $past(r.cs_s2 || r.rc_s2, 2) && !$past(trig_low))
		else $error("start without combined falling edge");

	AST_BUSY_SPAN: assert property (
		$fell(busy_n) |-> ##300 (!busy_n || $past(r.lu_s2, 2) || r.guard))
		else $error("busy rose before conversion end");

	AST_BUSY_DATA: assert property (
		$rose(busy_n) && !r.guard |-> result == $past(f_data))
		else $error("busy rose without new result");

	AST_GUARD_SET: assert property (
		r.lu_s2 |=> latchup_guard && !result_oe)
		else $error("guard not raised on latchup");

	AST_LATCH_RESET: assert property (
		r.lu_s2 |=> busy_n && r.st == S_IDLE && result == RES_RESET)
		else $error("latchup did not reset converter");

	AST_MSB_FIRST: assert property (
		$fell(busy_n) |-> dac_code == TRIAL_MSB)
		else $error("conversion did not begin at msb");

	AST_CONV_TIME: assert property (
		$fell(busy_n) |-> ##[1:338] (r.st == S_DONE || r.lu_s2))
		else $error("conversion overran its time");

	AST_DRIVE_QUIET: assert property (
		(r.guard || !busy_n) |=> !result_oe)
		else $error("data driven while busy or guarded");

	COV_CONVERT: cover property (
		$fell(busy_n) ##[300:340] $rose(busy_n));
	COV_READ: cover property ($rose(busy_n) ##[1:20] result_oe);
	COV_LATCHUP: cover property (!busy_n ##1 latchup_guard);
	COV_ACQ_RESTART: cover property (r.st == S_ACQ ##1 r.st == S_CONV);

endmodule
`default_nettype wire

// ### rtl/sac_fifo.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Small FIFO, registered head word, synchronous clear
module sac_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             clear,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	import sac_pkg::*;

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [PW:0]                 cnt;
		logic                        ov;
		logic [WIDTH-1:0]            od;
	} sac_fifo_s;

	sac_fifo_s r;
	sac_fifo_s next_r;

	////////////////////////////////////////////////////////////////////
	// Depth must be a power of two for pointer wrap
	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop  = 1'b0;
		next_r = r;
		in_ready = (r.cnt < (PW+1)'(DEPTH));
		push = in_valid && in_ready;
		pop  = (r.cnt != '0) && (!r.ov || out_ready);
		if (push) begin
			next_r.mem[r.wp] = in_data;
			next_r.wp = r.wp + 1'b1;
		end
		if (pop) begin
			next_r.od = r.mem[r.rp];
			next_r.ov = 1'b1;
			next_r.rp = r.rp + 1'b1;
		end else if (out_ready) begin
			next_r.ov = 1'b0;
		end
		next_r.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
		if (clear) begin
			next_r = '0;
			next_r.mem = r.mem;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign out_valid = r.ov;
	assign out_data  = r.od;

endmodule
`default_nettype wire

// ### rtl/sac_pkg.sv
////////////////////////////////////////////////////////////////////////
// Constants shared by the conversion interface and its result FIFO
package sac_pkg;

	// Result word
	localparam int unsigned RES_W      = 16;
	localparam int unsigned RES_MSB    = 15;
	localparam int unsigned RES_LSB    = 0;
	localparam logic [15:0] RES_RESET  = 16'h0000;
	localparam logic [15:0] TRIAL_MSB  = 16'h8000;

	// Timing, printed figures in ns
	localparam int unsigned CLK_NS     = 25;
	localparam int unsigned CONV_NS    = 8000;
	localparam int unsigned CYCLE_NS   = 10000;

	// Longest times round down to whole clocks
	localparam int unsigned CONV_CYC   = CONV_NS / CLK_NS;
	localparam int unsigned CYCLE_CYC  = CYCLE_NS / CLK_NS;
	localparam int unsigned BIT_CYC    = CONV_CYC / RES_W;
	// Sync, done, FIFO and load stages eaten out of the sample period
	localparam int unsigned PIPE_CYC   = 6;
	localparam int unsigned ACQ_CYC    = CYCLE_CYC - CONV_CYC - PIPE_CYC;

	localparam int unsigned CNT_W      = 9;
	localparam int unsigned BIT_W      = 4;
	localparam logic [3:0]  BIT_TOP    = 4'hf;
	localparam logic [3:0]  BIT_ZERO   = 4'h0;

	// Result FIFO
	localparam int unsigned FIFO_DEPTH = 8;

	// Default hold of the guard flag after the latchup input clears
	localparam int unsigned GUARD_HOLD = 40;

	typedef enum logic [2:0] {
		S_IDLE,
		S_CONV,
		S_DONE,
		S_WAIT,
		S_ACQ
	} sac_state_e;

endpackage

// ### verification/sac_host.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Host side of the select and read/convert pins
module sac_host (
	input  wire logic        clk,
	input  wire logic        guard,
	input  wire logic [15:0] data,
	input  wire logic        data_oe,
	output logic             cs_n,
	output logic             rc,
	output logic      [15:0] bus
);
	logic want_cs_n = 1'b1;
	logic want_rc   = 1'b1;

	assign cs_n = want_cs_n & ~guard;
	assign rc   = want_rc & ~guard;
	// no pull-up while guarded; an undriven bus reads inverted
	assign bus  = data_oe ? data : (guard ? 16'h0000 : ~data);

	// Change only just after an edge
	task automatic pins(input logic c, input logic r);
		@(posedge clk);
		want_cs_n <= c;
		want_rc   <= r;
	endtask
endmodule
`default_nettype wire

// ### verification/test_sac_conv.sv
`timescale 1ns/1ps
`default_nettype none
module test_sac_conv;
	import sac_pkg::*;
	logic        clk;
	logic        rst         = 1'b1;
	logic        latchup_hit = 1'b0;
	logic        cmp_hi      = 1'b0;
	logic [15:0] target      = 16'h0000;
	wire  logic  cs_n;
	wire  logic  rc;
	wire  logic [15:0] bus;
	logic [15:0] dac_code;
	logic        sample_hold;
	logic        busy_n;
	logic        latchup_guard;
	logic [15:0] result;
	logic        result_oe;
	int          fail_count  = 0;
	int          n_compared  = 0;

	sac_host host (.clk(clk), .guard(latchup_guard), .data(result),
		.data_oe(result_oe), .cs_n(cs_n), .rc(rc), .bus(bus));
	// Short guard hold keeps the run brief
	sac_conv #(.HOLD_CYC(2)) dut (
		.clk(clk), .rst(rst), .cs_n(cs_n), .rc(rc),
		.latchup_hit(latchup_hit), .cmp_hi(cmp_hi), .dac_code(dac_code),
		.sample_hold(sample_hold), .busy_n(busy_n),
		.latchup_guard(latchup_guard), .result(result),
		.result_oe(result_oe));

	// Ideal comparator: keep the trial bit if not above the input
	always @(posedge clk) cmp_hi <= (dac_code <= target);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input string nm, input logic [15:0] seen,
			input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Bounded wait on busy or guard, returns the cycles spent
	task automatic wait_for(input string nm, input logic on_guard,
			input logic lvl, output int n);
		n = 0;
		while ((on_guard ? latchup_guard : busy_n) !== lvl) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 600) begin
				fail_count++;
				$display("[FAIL] %s wait ran out", nm);
				print_verdict();
			end
		end
	endtask

	task automatic read_word(input logic [15:0] exp);
		host.pins(1'b0, 1'b1);
		repeat (5) @(posedge clk);
		#1;
		check("result_oe on", result_oe, 1'b1);
		check("result", result, exp);
		check("bus", bus, exp);
		host.pins(1'b1, 1'b1);
		repeat (5) @(posedge clk);
		#1;
		check("result_oe off", result_oe, 1'b0);
		// Let the acquire window pass before the next trigger
		repeat (80) @(posedge clk);
	endtask

	// Last falling pin of the two starts the conversion
	task automatic convert(input logic [15:0] t, input logic by_cs);
		int n;
		target <= t;
		host.pins(by_cs, ~by_cs);
		repeat (5) @(posedge clk);
		host.pins(1'b0, 1'b0);
		wait_for("busy low", 1'b0, 1'b0, n);
		check("start delay ok", n <= 6, 1'b1);
		check("hold in convert", sample_hold, 1'b1);
		wait_for("busy high", 1'b0, 1'b1, n);
		check("busy length", n >= CONV_CYC && n < CYCLE_CYC, 1'b1);
		read_word(t);
	endtask

	task automatic latchup_mid_conv();
		int n;
		target <= 16'h1234;
		host.pins(1'b0, 1'b1);
		repeat (5) @(posedge clk);
		host.pins(1'b0, 1'b0);
		wait_for("busy low", 1'b0, 1'b0, n);
		repeat (100) @(posedge clk);
		latchup_hit <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		check("guard", latchup_guard, 1'b1);
		check("busy idle", busy_n, 1'b1);
		check("result cleared", result, 16'h0000);
		check("oe off", result_oe, 1'b0);
		check("bus quiet", bus, 16'h0000);
		@(posedge clk);
		latchup_hit <= 1'b0;
		host.pins(1'b1, 1'b1);
		wait_for("guard low", 1'b1, 1'b0, n);
		check("guard hold", n >= 2, 1'b1);
		repeat (80) @(posedge clk);
	endtask

	// Busy high in the tracking window, so a trigger there must start
	task automatic acq_trigger();
		int n;
		target <= 16'h4c21;
		host.pins(1'b1, 1'b0);
		repeat (5) @(posedge clk);
		host.pins(1'b0, 1'b0);
		wait_for("busy low", 1'b0, 1'b0, n);
		wait_for("busy high", 1'b0, 1'b1, n);
		target <= 16'h3e07;
		host.pins(1'b1, 1'b0);
		repeat (5) @(posedge clk);
		host.pins(1'b0, 1'b0);
		wait_for("busy low again", 1'b0, 1'b0, n);
		check("restart delay ok", n <= 6, 1'b1);
		wait_for("busy high again", 1'b0, 1'b1, n);
		read_word(16'h3e07);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check("reset busy", busy_n, 1'b1);
		check("reset guard", latchup_guard, 1'b0);
		check("reset oe", result_oe, 1'b0);
		check("reset result", result, RES_RESET);
		convert(16'hffff, 1'b0);
		convert(16'h0001, 1'b1);
		latchup_mid_conv();
		convert(16'ha5c3, 1'b0);
		convert(16'h8000, 1'b1);
		acq_trigger();
		print_verdict();
	end
endmodule
`default_nettype wire
